/* rtl/sipf_top.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`include "sipf_defines.svh"

// Summary of operation
// - one shot: reload frame 0, then halt
// - repeat: reload frame 0 and keep running
// - direction bit set: release the transmit pin
// - direction bit clear: drive the transmit pin
// - reverse bit swaps sine and cosine channels
// - interpolation factor is two to (n+2)
// - frame count held within 1 to 128
// - run frames 0 through count minus one
// - frame data pointer 0 to 255 selects location
module sipf_top
    import sipf_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_sin_quad,
    input  wire logic        i_cos_quad,
    input  wire logic [13:0] i_fine_phase,
    output logic      [31:0] o_position,
    output logic      [4:0]  o_interp_factor,
    input  wire logic        i_txpin_in,
    output logic             o_txpin_out,
    output logic             o_txpin_oe_n
);

    // ****************************************************************
    // functions
    // ****************************************************************

    // gray quadrant code to binary phase
    function automatic logic [1:0] sipf_quad_phase(input logic a, input logic b);
        sipf_quad_phase = {a, a ^ b};
    endfunction

    // hold a frame count inside its legal range
    function automatic logic [7:0] sipf_clamp_count(input logic [15:0] v);
        if (v < 16'(`SIPF_FRAME_COUNT_MIN)) begin
            sipf_clamp_count = `SIPF_FRAME_COUNT_MIN;
        end else if (v > 16'(`SIPF_FRAME_COUNT_MAX)) begin
            sipf_clamp_count = `SIPF_FRAME_COUNT_MAX;
        end else begin
            sipf_clamp_count = v[7:0];
        end
    endfunction

    // hold the factor field inside 0 to 14
    function automatic logic [3:0] sipf_clamp_factor(input logic [3:0] n);
        if (n > `SIPF_FACTOR_MAX) begin
            sipf_clamp_factor = `SIPF_FACTOR_MAX;
        end else begin
            sipf_clamp_factor = n;
        end
    endfunction

    // ****************************************************************
    // registers and state
    // ****************************************************************
    logic [15:0] interp_config;
    sipf_mode_t  mode;
    logic [7:0]  frame_count;
    logic [7:0]  frame_ptr;
    logic [15:0] frame_mem [0:255];
    logic [31:0] quad_count;
    logic [1:0]  prev_phase;
    logic        quad_valid;

    sipf_seq_if u_seq_if ();

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire logic sel_status = (i_addr == `SIPF_ADDR_STATUS);
    wire logic sel_mode   = (i_addr == `SIPF_ADDR_MODE);
    wire logic sel_config = (i_addr == `SIPF_ADDR_CONFIG);
    wire logic sel_rsvd_a = (i_addr == `SIPF_ADDR_RSVD_A);
    wire logic sel_rsvd_b = (i_addr == `SIPF_ADDR_RSVD_B);
    wire logic sel_count  = (i_addr == `SIPF_ADDR_FRAME_COUNT);
    wire logic sel_ptr    = (i_addr == `SIPF_ADDR_FRAME_PTR);
    wire logic sel_data   = (i_addr == `SIPF_ADDR_FRAME_DATA);

    // write strobes per register
    wire logic wr_mode   = i_wr && sel_mode;
    wire logic wr_config = i_wr && sel_config;
    wire logic wr_count  = i_wr && sel_count;
    wire logic wr_ptr    = i_wr && sel_ptr;
    wire logic wr_data   = i_wr && sel_data;
    wire logic rd_data   = i_rd && sel_data;

    // frame data only accepted while loading
    wire logic mem_we = wr_data && (mode == SIPF_MODE_LOAD);

    // ****************************************************************
    // configuration fields
    // ****************************************************************
    wire logic       cfg_repeat  = interp_config[`SIPF_CFG_REPEAT_BIT];
    wire logic       cfg_pindir  = interp_config[`SIPF_CFG_PINDIR_BIT];
    wire logic       cfg_reverse = interp_config[`SIPF_CFG_REVERSE_BIT];
    wire logic [3:0] cfg_factor  = sipf_clamp_factor(
        interp_config[`SIPF_CFG_FACTOR_MSB:`SIPF_CFG_FACTOR_LSB]);

    // reserved bits are dropped so they always read as zero
    wire logic [15:0] next_config = i_wdata & `SIPF_CFG_WRITE_MASK;

    // unknown mode codes fall back to setup
    wire logic [1:0] wmode    = i_wdata[1:0];
    wire logic       mode_ok  = (wmode == SIPF_MODE_LOAD) || (wmode == SIPF_MODE_RUN);
    wire sipf_mode_t next_mode = mode_ok ? sipf_mode_t'(wmode) : SIPF_MODE_SETUP;

    // ****************************************************************
    // control register writes
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            interp_config <= `SIPF_CFG_RESET;
            mode          <= SIPF_MODE_SETUP;
            frame_count   <= `SIPF_FRAME_COUNT_RESET;
        end else if (i_ce) begin
            if (wr_config) begin
                interp_config <= next_config;
            end
            if (wr_mode) begin
                mode <= next_mode;
            end
            if (wr_count) begin
                frame_count <= sipf_clamp_count(i_wdata);
            end
        end
    end

    // ****************************************************************
    // frame data pointer
    // ****************************************************************
    // explicit write wins, any data access advances by one
    wire logic [7:0] next_frame_ptr =
        wr_ptr                ? i_wdata[7:0] :
        (wr_data || rd_data)  ? frame_ptr + 8'h01 :
                                frame_ptr;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_ptr <= `SIPF_PTR_RESET;
        end else if (i_ce) begin
            frame_ptr <= next_frame_ptr;
        end
    end

    // ****************************************************************
    // frame memory
    // ****************************************************************
    // no reset on the array, contents are loaded by software
    always_ff @(posedge i_core_clk) begin
        if (i_ce && mem_we) begin
            frame_mem[frame_ptr] <= i_wdata;
        end
    end

    // ****************************************************************
    // frame sequencer hookup
    // ****************************************************************
    // engine runs only in run mode with the pin driven
    assign u_seq_if.enable      = (mode == SIPF_MODE_RUN) && !cfg_pindir;
    assign u_seq_if.repeat_on   = cfg_repeat;
    assign u_seq_if.frame_count = frame_count;
    assign u_seq_if.rd_data     = frame_mem[u_seq_if.rd_addr];

    sipf_frame_seq u_seq (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .bus        (u_seq_if.seq)
    );

    // ****************************************************************
    // shared transmit pin
    // ****************************************************************
    // enable high releases the pin to the node
    assign o_txpin_oe_n = cfg_pindir;
    assign o_txpin_out  = u_seq_if.pin_level;

    // ****************************************************************
    // status word
    // ****************************************************************
    wire logic [15:0] status_word = {
        1'b0,
        u_seq_if.frame_idx,
        4'h0,
        i_txpin_in,
        u_seq_if.pin_level,
        u_seq_if.halted,
        u_seq_if.running
    };

    // ****************************************************************
    // read data select
    // ****************************************************************
    wire logic [15:0] next_rdata =
        !i_rd      ? 16'h0000 :
        sel_status ? status_word :
        sel_mode   ? {14'h0000, mode} :
        sel_config ? interp_config :
        sel_rsvd_a ? 16'h0000 :
        sel_rsvd_b ? 16'h0000 :
        sel_count  ? {8'h00, frame_count} :
        sel_ptr    ? {8'h00, frame_ptr} :
        sel_data   ? frame_mem[frame_ptr] :
                     16'h0000;

    // read data stand one cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_ce) begin
            o_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // encoder channels
    // ****************************************************************
    // reverse swaps sine and cosine
    wire logic chan_a = cfg_reverse ? i_cos_quad : i_sin_quad;
    wire logic chan_b = cfg_reverse ? i_sin_quad : i_cos_quad;

    wire logic [1:0] cur_phase = sipf_quad_phase(chan_a, chan_b);
    wire logic [1:0] step      = cur_phase - prev_phase;

    // +1 forward, -1 backward, double steps ignored
    wire logic        step_up   = quad_valid && (step == 2'h1);
    wire logic        step_down = quad_valid && (step == 2'h3);
    wire logic [31:0] next_quad_count =
        step_up   ? quad_count + 32'h0000_0001 :
        step_down ? quad_count - 32'h0000_0001 :
                    quad_count;

    // ****************************************************************
    // quadrant counter
    // ****************************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_phase <= 2'h0;
            quad_valid <= 1'b0;
            quad_count <= 32'h0000_0000;
        end else if (i_ce) begin
            prev_phase <= cur_phase;
            quad_valid <= 1'b1;
            quad_count <= next_quad_count;
        end
    end

    // ****************************************************************
    // interpolated position
    // ****************************************************************
    // n fine bits appended below the quadrant count
    wire logic [4:0]  fine_drop = 5'(`SIPF_FINE_BITS) - {1'b0, cfg_factor};
    wire logic [31:0] fine_ext  = {18'h00000, i_fine_phase};
    wire logic [31:0] next_position =
        (quad_count << cfg_factor) | (fine_ext >> fine_drop);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_position      <= 32'h0000_0000;
            o_interp_factor <= `SIPF_FACTOR_OFFSET;
        end else if (i_ce) begin
            o_position      <= next_position;
            o_interp_factor <= {1'b0, cfg_factor} + `SIPF_FACTOR_OFFSET;
        end
    end

endmodule

/* rtl/sipf_defines.svh */
`ifndef SIPF_DEFINES_SVH
`define SIPF_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SIPF_ADDR_STATUS      8'hCC
`define SIPF_ADDR_MODE        8'hCD
`define SIPF_ADDR_CONFIG      8'hCE
`define SIPF_ADDR_RSVD_A      8'hCF
`define SIPF_ADDR_RSVD_B      8'hD0
`define SIPF_ADDR_FRAME_COUNT 8'hD1
`define SIPF_ADDR_FRAME_PTR   8'hD2
`define SIPF_ADDR_FRAME_DATA  8'hD3

// ****************************************************************
// configuration word fields and reset values
// ****************************************************************
`define SIPF_CFG_REPEAT_BIT   0
`define SIPF_CFG_PINDIR_BIT   1
`define SIPF_CFG_REVERSE_BIT  3
`define SIPF_CFG_FACTOR_LSB   12
`define SIPF_CFG_FACTOR_MSB   15
`define SIPF_CFG_WRITE_MASK   16'hF00B
`define SIPF_CFG_RESET        16'h0000
`define SIPF_FACTOR_MAX       4'hE
`define SIPF_FACTOR_OFFSET    5'h02

// ****************************************************************
// frame count and pointer limits
// ****************************************************************
`define SIPF_FRAME_COUNT_MIN   8'h01
`define SIPF_FRAME_COUNT_MAX   8'h80
`define SIPF_FRAME_COUNT_RESET 8'h01
`define SIPF_PTR_RESET         8'h00
`define SIPF_FINE_BITS         14

`endif

/* rtl/sipf_pkg.sv */
package sipf_pkg;

    // mode command encodings
    typedef enum logic [1:0] {
        SIPF_MODE_SETUP = 2'h0,
        SIPF_MODE_LOAD  = 2'h1,
        SIPF_MODE_RUN   = 2'h2
    } sipf_mode_t;

    // frame sequencer states
    typedef enum logic [4:0] {
        SIPF_ST_IDLE  = 5'h01,
        SIPF_ST_FETCH = 5'h02,
        SIPF_ST_LOW   = 5'h04,
        SIPF_ST_HIGH  = 5'h08,
        SIPF_ST_HALT  = 5'h10
    } sipf_seq_state_t;

endpackage

/* rtl/sipf_seq_if.sv */
`timescale 1ns/10ps
interface sipf_seq_if;
    logic        enable;
    logic        repeat_on;
    logic [7:0]  frame_count;
    logic [7:0]  rd_addr;
    logic [15:0] rd_data;
    logic        pin_level;
    logic        running;
    logic        halted;
    logic [6:0]  frame_idx;

    modport ctl (
        output enable, repeat_on, frame_count, rd_data,
        input  rd_addr, pin_level, running, halted, frame_idx
    );
    modport seq (
        input  enable, repeat_on, frame_count, rd_data,
        output rd_addr, pin_level, running, halted, frame_idx
    );
endinterface

/* rtl/sipf_frame_seq.sv */
`timescale 1ns/10ps
`include "sipf_defines.svh"
module sipf_frame_seq
    import sipf_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    sipf_seq_if.seq   bus
);

    sipf_seq_state_t state;
    logic [6:0]      frame;
    logic            phase;
    logic [15:0]     cnt;
    logic            pin_level;

    // ****************************************************************
    // decode
    // ****************************************************************
    // frame k: start word at 2k, stop word at 2k+1
    wire logic [6:0] last_frame = 7'(bus.frame_count - 8'h01);
    wire logic       is_last    = (frame == last_frame);
    wire logic       cnt_done   = (cnt == 16'h0000);

    assign bus.rd_addr   = {frame, phase};
    assign bus.pin_level = pin_level;
    assign bus.running   = (state != SIPF_ST_IDLE) && (state != SIPF_ST_HALT);
    assign bus.halted    = (state == SIPF_ST_HALT);
    assign bus.frame_idx = frame;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // leaving run mode always returns to idle, restarting at frame 0
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= SIPF_ST_IDLE;
            frame     <= 7'h00;
            phase     <= 1'b0;
            cnt       <= 16'h0000;
            pin_level <= 1'b0;
        end else if (i_ce) begin
            if (!bus.enable) begin
                state     <= SIPF_ST_IDLE;
                frame     <= 7'h00;
                phase     <= 1'b0;
                pin_level <= 1'b0;
            end else begin
                case (state)
                    SIPF_ST_IDLE: begin
                        frame <= 7'h00;
                        phase <= 1'b0;
                        state <= SIPF_ST_FETCH;
                    end
                    SIPF_ST_FETCH: begin
                        cnt   <= bus.rd_data;
                        state <= phase ? SIPF_ST_HIGH : SIPF_ST_LOW;
                    end
                    SIPF_ST_LOW: begin
                        pin_level <= 1'b0;
                        if (cnt_done) begin
                            phase <= 1'b1;
                            state <= SIPF_ST_FETCH;
                        end else begin
                            cnt <= cnt - 16'h0001;
                        end
                    end
                    SIPF_ST_HIGH: begin
                        pin_level <= 1'b1;
                        if (cnt_done) begin
                            phase <= 1'b0;
                            if (is_last) begin
                                frame <= 7'h00;
                                state <= bus.repeat_on ? SIPF_ST_FETCH : SIPF_ST_HALT;
                            end else begin
                                frame <= frame + 7'h01;
                                state <= SIPF_ST_FETCH;
                            end
                        end else begin
                            cnt <= cnt - 16'h0001;
                        end
                    end
                    SIPF_ST_HALT: begin
                        pin_level <= 1'b0;
                    end
                    default: begin
                        state <= SIPF_ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* testbench/sipf_top_chk.sv */
`timescale 1ns/10ps
module sipf_chk
    import sipf_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [4:0]  o_interp_factor,
    input wire logic        o_txpin_out,
    input wire logic        o_txpin_oe_n
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ****************************************************************
    // register bus and configuration
    // ****************************************************************
    chk_rdata_idle_zero: assert property (
        !$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data not idle");
    chk_rsvd_reads_zero: assert property (
        i_ce && i_rd && (i_addr == 8'hCF || i_addr == 8'hD0) |=> o_rdata == 16'h0000)
        else $error("reserved location not zero");
    chk_cfg_readback_mask: assert property (
        i_wr && i_addr == 8'hCE ##1 i_rd && i_addr == 8'hCE
        |=> o_rdata == ($past(i_wdata, 2) & 16'hF00B)) else $error("config readback wrong");
    chk_cfg_oe_bit: assert property (
        i_ce && i_wr && i_addr == 8'hCE |=> o_txpin_oe_n == $past(i_wdata[1]))
        else $error("pin enable not following config");
    chk_pin_quiet_released: assert property (
        $past(o_txpin_oe_n) && o_txpin_oe_n |-> !o_txpin_out)
        else $error("pin active while released");
    chk_factor_from_cfg: assert property (
        i_ce && i_wr && i_addr == 8'hCE ##1 !(i_wr && i_addr == 8'hCE)
        |=> o_interp_factor == (($past(i_wdata[15:12], 2) > 4'hE) ? 5'h10
            : {1'b0, $past(i_wdata[15:12], 2)} + 5'h02)) else $error("factor wrong");

    // ****************************************************************
    // frame count and pointer
    // ****************************************************************
    chk_count_clamped: assert property (
        i_wr && i_addr == 8'hD1 ##1 i_rd && i_addr == 8'hD1
        |=> o_rdata == (($past(i_wdata, 2) == 16'h0000) ? 16'h0001
            : ($past(i_wdata, 2) > 16'h0080) ? 16'h0080 : $past(i_wdata, 2)))
        else $error("frame count not clamped");
    chk_ptr_loaded: assert property (
        i_wr && i_addr == 8'hD2 ##1 i_rd && i_addr == 8'hD2
        |=> o_rdata[7:0] == $past(i_wdata[7:0], 2)) else $error("pointer not loaded");
    chk_ptr_steps: assert property (
        i_wr && i_addr == 8'hD2 ##1 i_rd && i_addr == 8'hD3 ##1 i_rd && i_addr == 8'hD2
        |=> o_rdata[7:0] == $past(i_wdata[7:0], 3) + 8'h01) else $error("pointer not stepped");
endmodule

bind sipf_top sipf_chk sipf_chk_i (
    .i_core_clk      (i_core_clk),
    .i_rst_n         (i_rst_n),
    .i_ce            (i_ce),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .o_interp_factor (o_interp_factor),
    .o_txpin_out     (o_txpin_out),
    .o_txpin_oe_n    (o_txpin_oe_n)
);

/* testbench/sipf_node_model.sv */
`timescale 1ns/10ps
module sipf_node_model (
    input  wire logic i_dev_oe_n,
    input  wire logic i_dev_out,
    input  wire logic i_node_level,
    output logic      o_wire
);
    logic node_drive;
    // node drives only once the device has let go of the pin
    assign node_drive = i_dev_oe_n;
    assign o_wire     = node_drive ? i_node_level : i_dev_out;
endmodule

/* testbench/sipf_top_test.sv */
`timescale 1ns/10ps
module sipf_top_test
    import sipf_pkg::*;
;
    logic        i_core_clk, i_rst_n, i_ce, i_wr, i_rd, i_sin_quad, i_cos_quad;
    logic        o_txpin_out, o_txpin_oe_n, txpin_wire, node_level;
    logic [7:0]  i_addr;
    logic [15:0] i_wdata, o_rdata;
    logic [13:0] i_fine_phase;
    logic [31:0] o_position;
    logic [4:0]  o_interp_factor;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;

    sipf_top sipf_top_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sin_quad(i_sin_quad), .i_cos_quad(i_cos_quad), .i_fine_phase(i_fine_phase),
        .o_position(o_position), .o_interp_factor(o_interp_factor),
        .i_txpin_in(txpin_wire), .o_txpin_out(o_txpin_out), .o_txpin_oe_n(o_txpin_oe_n));
    sipf_node_model sipf_node_model_i (.i_dev_oe_n(o_txpin_oe_n), .i_dev_out(o_txpin_out),
        .i_node_level(node_level), .o_wire(txpin_wire));

    // ****************************************************************
    // clock, watchdog and helpers
    // ****************************************************************
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // cut a hang short
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            conclude;
        end
    end
    task automatic conclude;
        $display("compared %0d values, %0d mismatches", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle; m nonzero checks the previous read's data under mask m
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [15:0] d, input logic [15:0] m, input logic [15:0] e);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        @(negedge i_core_clk);
        if (m != 16'h0000) chk({16'h0, o_rdata & m}, {16'h0, e});
        @(posedge i_core_clk);
    endtask
    task automatic wr1(input logic [7:0] a, input logic [15:0] d);
        op(1'b1, 1'b0, a, d, 16'h0, 16'h0);
        op(1'b0, 1'b0, a, d, 16'h0, 16'h0);
    endtask
    task automatic rd1(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        op(1'b0, 1'b1, a, 16'h0, 16'h0, 16'h0);
        op(1'b0, 1'b0, a, 16'h0, m, e);
    endtask
    // count pulses and the widths of the first two; pin enable checked each cycle
    task automatic watch(input int n, input logic oe, output int r, output int w0,
                         output int w1);
        logic prev;
        r = 0;
        w0 = 0;
        w1 = 0;
        prev = 1'b0;
        repeat (n) begin
            @(negedge i_core_clk);
            chk({31'h0, o_txpin_oe_n}, {31'h0, oe});
            if (o_txpin_out === 1'b1) begin
                if (prev !== 1'b1) r++;
                if (r == 1) w0++;
                else if (r == 2) w1++;
            end
            prev = o_txpin_out;
        end
        @(posedge i_core_clk);
    endtask
    task automatic spin(output logic [31:0] d);
        logic [31:0] p0;
        @(negedge i_core_clk);
        p0 = o_position;
        @(posedge i_core_clk);
        for (int k = 1; k < 5; k++) begin
            i_sin_quad <= k[1];
            i_cos_quad <= k[1] ^ k[0];
            repeat (3) @(posedge i_core_clk);
        end
        @(negedge i_core_clk);
        d = o_position - p0;
        @(posedge i_core_clk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_values;
        logic [7:0]  ra [7] = '{8'hCE, 8'hCD, 8'hD1, 8'hD2, 8'hCF, 8'hD0, 8'h40};
        logic [15:0] rv [7] = '{16'h0, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0};
        logic [15:0] cw [5] = '{16'h0000, 16'h0001, 16'h0080, 16'h0081, 16'hFFFF};
        logic [15:0] cx [5] = '{16'h0001, 16'h0001, 16'h0080, 16'h0080, 16'h0080};
        @(negedge i_core_clk);
        chk({27'h0, o_interp_factor}, 32'h2);
        @(posedge i_core_clk);
        foreach (ra[k]) rd1(ra[k], 16'hFFFF, rv[k]);
        op(1'b1, 1'b0, 8'hCE, 16'hF00B, 16'h0, 16'h0);
        op(1'b0, 1'b1, 8'hCE, 16'h0, 16'h0, 16'h0);
        op(1'b0, 1'b0, 8'hCE, 16'h0, 16'hFFFF, 16'hF00B);
        foreach (cw[k]) begin
            op(1'b1, 1'b0, 8'hD1, cw[k], 16'h0, 16'h0);
            op(1'b0, 1'b1, 8'hD1, 16'h0, 16'h0, 16'h0);
            op(1'b0, 1'b0, 8'hD1, 16'h0, 16'hFFFF, cx[k]);
        end
        wr1(8'hCD, 16'h0001);
        wr1(8'hCD, 16'h0003);
        rd1(8'hCD, 16'hFFFF, 16'h0000);
    endtask
    task automatic t_factor;
        for (int n = 0; n < 16; n++) begin
            wr1(8'hCE, {n[3:0], 12'h000});
            @(negedge i_core_clk);
            chk({27'h0, o_interp_factor}, (n > 14) ? 32'd16 : 32'(n + 2));
            @(posedge i_core_clk);
        end
    endtask
    task automatic t_frames;
        int r, w0, w1;
        logic [15:0] words [4] = '{16'h0001, 16'h0002, 16'h0000, 16'h0003};
        wr1(8'hCE, 16'h0000);
        wr1(8'hD1, 16'h0002);
        wr1(8'hCD, 16'h0001);
        wr1(8'hD2, 16'h0000);
        foreach (words[k]) wr1(8'hD3, words[k]);
        wr1(8'hCD, 16'h0002);
        watch(40, 1'b0, r, w0, w1);
        chk(r, 2);
        chk(w0, 4);
        chk(w1, 4);
        rd1(8'hCC, 16'h0003, 16'h0002);
        wr1(8'hCD, 16'h0000);
        wr1(8'hCD, 16'h0002);
        watch(40, 1'b0, r, w0, w1);
        chk(r, 2);
        wr1(8'hCD, 16'h0000);
        wr1(8'hCE, 16'h0001);
        wr1(8'hCD, 16'h0002);
        watch(70, 1'b0, r, w0, w1);
        chk((r >= 4) ? 32'h1 : 32'h0, 32'h1);
        wr1(8'hCD, 16'h0000);
        wr1(8'hCE, 16'h0003);
        wr1(8'hCD, 16'h0002);
        node_level <= 1'b1;
        watch(30, 1'b1, r, w0, w1);
        chk(r, 0);
        rd1(8'hCC, 16'h0008, 16'h0008);
        node_level <= 1'b0;
        rd1(8'hCC, 16'h0008, 16'h0000);
        wr1(8'hCE, 16'h0001);
        watch(30, 1'b0, r, w0, w1);
        chk((r >= 1) ? 32'h1 : 32'h0, 32'h1);
        wr1(8'hCD, 16'h0000);
    endtask
    task automatic t_pointer;
        op(1'b1, 1'b0, 8'hD2, 16'h00FF, 16'h0, 16'h0);
        op(1'b0, 1'b1, 8'hD3, 16'h0, 16'h0, 16'h0);
        op(1'b0, 1'b1, 8'hD2, 16'h0, 16'h0, 16'h0);
        op(1'b0, 1'b0, 8'hD2, 16'h0, 16'hFFFF, 16'h0000);
        op(1'b1, 1'b0, 8'hD2, 16'h0001, 16'h0, 16'h0);
        op(1'b0, 1'b1, 8'hD3, 16'h0, 16'h0, 16'h0);
        op(1'b0, 1'b1, 8'hD3, 16'h0, 16'hFFFF, 16'h0002);
        op(1'b1, 1'b0, 8'hD3, 16'h0007, 16'hFFFF, 16'h0000);
        op(1'b0, 1'b1, 8'hD2, 16'h0, 16'h0, 16'h0);
        op(1'b0, 1'b0, 8'hD2, 16'h0, 16'hFFFF, 16'h0004);
        wr1(8'hD2, 16'h0003);
        rd1(8'hD3, 16'hFFFF, 16'h0003);
        op(1'b1, 1'b0, 8'hD2, 16'h0080, 16'h0, 16'h0);
        op(1'b0, 1'b1, 8'hD2, 16'h0, 16'h0, 16'h0);
        op(1'b0, 1'b0, 8'hD2, 16'h0, 16'hFFFF, 16'h0080);
    endtask
    task automatic t_reverse;
        logic [31:0] d1, d2;
        wr1(8'hCE, 16'h0000);
        spin(d1);
        chk((d1 == 32'h4 || d1 == 32'hFFFF_FFFC) ? 32'h1 : 32'h0, 32'h1);
        wr1(8'hCE, 16'h0008);
        spin(d2);
        chk(d2, 32'h0 - d1);
    endtask

    // main sequence
    initial begin
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 16'h0000;
        i_sin_quad = 1'b0;
        i_cos_quad = 1'b0;
        i_fine_phase = 14'h0000;
        node_level = 1'b0;
        repeat (8) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        t_reset_values;
        t_factor;
        t_frames;
        t_pointer;
        t_reverse;
        conclude;
    end
endmodule
